//--- otfs_pkg.sv
// Constants, carrier types and register map for the output terminal function selector.
// Assumes one clock at 40 MHz and an AHB-Lite master driving single word transfers.
package otfs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OTFS_FIRST_FUNC_ADDR = 8'h00;
  localparam logic [7:0] OTFS_SECOND_FUNC_ADDR = 8'h04;
  localparam logic [7:0] OTFS_RELAY_FUNC_ADDR = 8'h08;
  localparam logic [7:0] OTFS_POLARITY_ADDR = 8'h0c;
  localparam logic [7:0] OTFS_LINK_DATA_ADDR = 8'h10;
  localparam logic [7:0] OTFS_WOBBLE_EN_ADDR = 8'h14;
  localparam logic [7:0] OTFS_STATUS_ADDR = 8'h18;

  localparam logic [5:0] OTFS_FIRST_FUNC_RST = 6'h02;
  localparam logic [5:0] OTFS_SECOND_FUNC_RST = 6'h00;
  localparam logic [5:0] OTFS_RELAY_FUNC_RST = 6'h1f;
  localparam logic [2:0] OTFS_POLARITY_RST = 3'h0;

  localparam int OTFS_TERMS = 3;
  localparam int OTFS_SECOND_IDX = 1;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OTFS_F_UNUSED = 6'h00, OTFS_F_WOBBLE = 6'h0e, OTFS_F_SEQ_RUN = 6'h0f,
    OTFS_F_SEQ_PAUSE = 6'h10, OTFS_F_SEQ_CYCLE = 6'h11, OTFS_F_SEQ_STEP = 6'h12,
    OTFS_F_SEQ_DONE = 6'h13, OTFS_F_LINK = 6'h14, OTFS_F_RUNTIME = 6'h15,
    OTFS_F_TIMING = 6'h16, OTFS_F_CNT_PRESET = 6'h17, OTFS_F_CNT_IND = 6'h18,
    OTFS_F_LENGTH = 6'h19, OTFS_F_ANALOG = 6'h1b, OTFS_F_UNDERVOLT = 6'h1d,
    OTFS_F_OVERLOAD = 6'h1e, OTFS_F_FAULT = 6'h1f, OTFS_F_EXT_FAULT = 6'h20,
    OTFS_F_AUTO_RESET = 6'h21, OTFS_F_HIGH_FREQ = 6'h26
  } otfs_func_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OTFS_CLK_HZ = 40000000;
  localparam int OTFS_PULSE_MS = 500;
  localparam int OTFS_PULSE_CYC = OTFS_CLK_HZ / 1000 * OTFS_PULSE_MS;
  localparam int OTFS_PW = 25;

  // ----------------------------------------------------------------
  // Status carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wobble_high;
    logic wobble_low;
    logic seq_running;
    logic seq_paused;
    logic seq_cycle_done;
    logic seq_step_done;
    logic seq_run_done;
    logic runtime_reached;
    logic timing_out;
    logic count_preset;
    logic count_indicate;
    logic length_reached;
    logic analog_overrun;
    logic undervolt;
    logic overload_alarm;
    logic drive_fault;
    logic ext_fault;
    logic auto_reset;
    logic high_freq;
  } otfs_status_t;

  typedef struct packed {
    logic cycle;
    logic step;
    logic done;
    logic runtime;
  } otfs_events_t;

endpackage : otfs_pkg

//--- otfs_pulse.sv
// Pulse stretcher: each rising edge of an event outside a pulse gives one fixed-length pulse.
// Assumes the event is synchronous to the clock.
`timescale 1ns/10ps
module otfs_pulse
  import otfs_pkg::*;
#(
  parameter int LEN = OTFS_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic event_i,
  output logic pulse_o
);

  typedef struct packed {
    logic prev;
    logic [OTFS_PW-1:0] cnt;
  } otfs_pulse_st_t;

  otfs_pulse_st_t st_q, st_d;

  // Retrigger during a pulse is ignored: one pulse per event, not per edge burst
  always_comb begin
    st_d = st_q;
    st_d.prev = event_i;
    if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end else if (event_i && !st_q.prev) begin
      st_d.cnt = OTFS_PW'(LEN);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse_o = (st_q.cnt != '0);

  property p_pulse_len;
    @(posedge clk_i) disable iff (!rst_b_i)
    (event_i && !st_q.prev && st_q.cnt == '0) |=> (st_q.cnt == OTFS_PW'(LEN));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse not loaded");

endmodule : otfs_pulse

//--- otfs_top.sv
// Output terminal function selector: maps drive states onto two collector outputs and a relay.
// Assumes status inputs are synchronous to MCLK_I and an AHB-Lite master on the register bus.
`timescale 1ns/10ps
module otfs_top
  import otfs_pkg::*;
#(
  parameter int PULSE_CYC = OTFS_PULSE_CYC
) (
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire otfs_status_t STATUS_I,
  output logic FIRST_COLLECTOR_OUTPUT_O,
  output logic SECOND_COLLECTOR_OUTPUT_O,
  output logic RELAY_OUTPUT_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [OTFS_TERMS-1:0][5:0] func;
    logic [2:0] polarity;
    logic [2:0] link_data;
    logic wobble_enable_param;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic [2:0] outs;
  } otfs_st_t;

  otfs_st_t st_q, st_d;
  otfs_events_t pulses;
  logic [OTFS_TERMS-1:0] raw;
  logic [OTFS_TERMS-1:0] term_level;
  logic addr_phase;

  // ----------------------------------------------------------------
  // Event pulse stretchers
  // ----------------------------------------------------------------
  otfs_pulse #(.LEN(PULSE_CYC)) u_cycle (
    .clk_i(MCLK_I), .rst_b_i(RST_B_I), .event_i(STATUS_I.seq_cycle_done), .pulse_o(pulses.cycle)
  );
  otfs_pulse #(.LEN(PULSE_CYC)) u_step (
    .clk_i(MCLK_I), .rst_b_i(RST_B_I), .event_i(STATUS_I.seq_step_done), .pulse_o(pulses.step)
  );
  otfs_pulse #(.LEN(PULSE_CYC)) u_done (
    .clk_i(MCLK_I), .rst_b_i(RST_B_I), .event_i(STATUS_I.seq_run_done), .pulse_o(pulses.done)
  );
  otfs_pulse #(.LEN(PULSE_CYC)) u_rtime (
    .clk_i(MCLK_I), .rst_b_i(RST_B_I), .event_i(STATUS_I.runtime_reached),
    .pulse_o(pulses.runtime)
  );

  // ----------------------------------------------------------------
  // Per-terminal function select
  // ----------------------------------------------------------------
  for (genvar t = 0; t < OTFS_TERMS; t++) begin : g_term
    always_comb begin
      raw[t] = 1'b0;
      case (st_q.func[t])
        OTFS_F_WOBBLE: begin
          raw[t] = st_q.wobble_enable_param
            && (STATUS_I.wobble_high || STATUS_I.wobble_low);
        end
        OTFS_F_SEQ_RUN: raw[t] = STATUS_I.seq_running;
        OTFS_F_SEQ_PAUSE: raw[t] = STATUS_I.seq_paused;
        OTFS_F_SEQ_CYCLE: raw[t] = pulses.cycle;
        OTFS_F_SEQ_STEP: raw[t] = pulses.step;
        OTFS_F_SEQ_DONE: raw[t] = pulses.done;
        OTFS_F_LINK: raw[t] = st_q.link_data[t];
        OTFS_F_RUNTIME: raw[t] = pulses.runtime;
        OTFS_F_TIMING: raw[t] = STATUS_I.timing_out;
        OTFS_F_CNT_PRESET: raw[t] = STATUS_I.count_preset;
        OTFS_F_CNT_IND: raw[t] = STATUS_I.count_indicate;
        OTFS_F_LENGTH: raw[t] = STATUS_I.length_reached;
        OTFS_F_ANALOG: raw[t] = STATUS_I.analog_overrun;
        OTFS_F_UNDERVOLT: raw[t] = STATUS_I.undervolt;
        // Producer already applies threshold and detection time
        OTFS_F_OVERLOAD: raw[t] = STATUS_I.overload_alarm;
        OTFS_F_FAULT: raw[t] = STATUS_I.drive_fault;
        OTFS_F_EXT_FAULT: raw[t] = STATUS_I.ext_fault;
        OTFS_F_AUTO_RESET: raw[t] = STATUS_I.auto_reset;
        OTFS_F_HIGH_FREQ: raw[t] = (t == OTFS_SECOND_IDX) && STATUS_I.high_freq;
        default: raw[t] = 1'b0;
      endcase
      term_level[t] = raw[t] ^ st_q.polarity[t];
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];

  always_comb begin
    st_d = st_q;
    st_d.outs = term_level;
    st_d.wr_pend = addr_phase && HWRITE_I;
    if (addr_phase) begin
      st_d.wr_addr = HADDR_I[7:0];
    end
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        OTFS_FIRST_FUNC_ADDR: st_d.func[0] = HWDATA_I[5:0];
        OTFS_SECOND_FUNC_ADDR: st_d.func[1] = HWDATA_I[5:0];
        OTFS_RELAY_FUNC_ADDR: st_d.func[2] = HWDATA_I[5:0];
        OTFS_POLARITY_ADDR: st_d.polarity = HWDATA_I[2:0];
        OTFS_LINK_DATA_ADDR: st_d.link_data = HWDATA_I[2:0];
        OTFS_WOBBLE_EN_ADDR: st_d.wobble_enable_param = HWDATA_I[0];
        default: ;
      endcase
    end
    if (addr_phase && !HWRITE_I) begin
      unique case (HADDR_I[7:0])
        OTFS_FIRST_FUNC_ADDR: st_d.rdata = {26'h0, st_q.func[0]};
        OTFS_SECOND_FUNC_ADDR: st_d.rdata = {26'h0, st_q.func[1]};
        OTFS_RELAY_FUNC_ADDR: st_d.rdata = {26'h0, st_q.func[2]};
        OTFS_POLARITY_ADDR: st_d.rdata = {29'h0, st_q.polarity};
        OTFS_LINK_DATA_ADDR: st_d.rdata = {29'h0, st_q.link_data};
        OTFS_WOBBLE_EN_ADDR: st_d.rdata = {31'h0, st_q.wobble_enable_param};
        OTFS_STATUS_ADDR: st_d.rdata = {29'h0, st_q.outs};
        default: st_d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_q <= '0;
      st_q.func[0] <= OTFS_FIRST_FUNC_RST;
      st_q.func[1] <= OTFS_SECOND_FUNC_RST;
      st_q.func[2] <= OTFS_RELAY_FUNC_RST;
      st_q.polarity <= OTFS_POLARITY_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Always ready, always OKAY: every access completes in its first data cycle
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = st_q.rdata;
  assign FIRST_COLLECTOR_OUTPUT_O = st_q.outs[0];
  assign SECOND_COLLECTOR_OUTPUT_O = st_q.outs[1];
  assign RELAY_OUTPUT_O = st_q.outs[2];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_unused_idle;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[0] == OTFS_F_UNUSED) |=> (FIRST_COLLECTOR_OUTPUT_O == $past(st_q.polarity[0]));
  endproperty
  a_unused_idle: assert property (p_unused_idle) else $error("unused code drove output");

  property p_hf_only_second;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[0] == OTFS_F_HIGH_FREQ && !st_q.polarity[0]) |=> !FIRST_COLLECTOR_OUTPUT_O;
  endproperty
  a_hf_only_second: assert property (p_hf_only_second) else $error("hf on first output");

  property p_wobble_gate;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[1] == OTFS_F_WOBBLE && !st_q.wobble_enable_param && !st_q.polarity[1])
      |=> !SECOND_COLLECTOR_OUTPUT_O;
  endproperty
  a_wobble_gate: assert property (p_wobble_gate) else $error("wobble without enable");

  property p_fault_relay;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[2] == OTFS_F_FAULT) |=> (RELAY_OUTPUT_O == ($past(STATUS_I.drive_fault)
      ^ $past(st_q.polarity[2])));
  endproperty
  a_fault_relay: assert property (p_fault_relay) else $error("fault not on relay");

  property p_link_drive;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[0] == OTFS_F_LINK) |=> (FIRST_COLLECTOR_OUTPUT_O == ($past(st_q.link_data[0])
      ^ $past(st_q.polarity[0])));
  endproperty
  a_link_drive: assert property (p_link_drive) else $error("link value not driven");

  property p_seq_run;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[1] == OTFS_F_SEQ_RUN && !st_q.polarity[1] && STATUS_I.seq_running)
      |=> SECOND_COLLECTOR_OUTPUT_O;
  endproperty
  a_seq_run: assert property (p_seq_run) else $error("sequencer run not shown");

  property p_undervolt;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[2] == OTFS_F_UNDERVOLT && !st_q.polarity[2] && STATUS_I.undervolt)
      |=> RELAY_OUTPUT_O;
  endproperty
  a_undervolt: assert property (p_undervolt) else $error("undervoltage not shown");

  property p_undoc_idle;
    @(posedge MCLK_I) disable iff (!RST_B_I)
    (st_q.func[2] == 6'h1a && !st_q.polarity[2]) |=> !RELAY_OUTPUT_O;
  endproperty
  a_undoc_idle: assert property (p_undoc_idle) else $error("undocumented code active");

endmodule : otfs_top

//--- otfs_load.sv
// Load model for the terminals: relay coils or lamps that count their on-cycles.
// Assumes each terminal is a level that is sampled on the rising clock edge.
`timescale 1ns/10ps
module otfs_load (
  input wire logic clk_i,
  input wire logic clear_i,
  input wire logic [2:0] line_i,
  output logic [15:0] first_cnt_o,
  output logic [15:0] second_cnt_o,
  output logic [15:0] relay_cnt_o
);
  // ------------------------------------------------------------
  // On-time counters
  // ------------------------------------------------------------
  // Counting whole cycles catches a pulse that is short, long or retriggered
  always @(posedge clk_i) begin
    if (clear_i) begin
      first_cnt_o <= 16'h0;
      second_cnt_o <= 16'h0;
      relay_cnt_o <= 16'h0;
    end else begin
      first_cnt_o <= first_cnt_o + 16'(line_i[0]);
      second_cnt_o <= second_cnt_o + 16'(line_i[1]);
      relay_cnt_o <= relay_cnt_o + 16'(line_i[2]);
    end
  end
endmodule : otfs_load

//--- otfs_bench.sv
// Testbench for the output terminal function selector.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready, and a short pulse length.
`timescale 1ns/10ps
module otfs_bench;
  import otfs_pkg::*;
  localparam int PCYC = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  otfs_status_t st = '0;
  logic o1, o2, o3;
  logic [2:0] outs;
  logic clear = 1'b0;
  logic [15:0] c1, c2, c3;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] r;
  logic [5:0] lvl_code [14] = '{6'h0e, 6'h0e, 6'h0f, 6'h10, 6'h16, 6'h17, 6'h18, 6'h19,
    6'h1b, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21};
  int lvl_bit [14] = '{18, 17, 16, 15, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1};
  logic [5:0] pul_code [4] = '{6'h11, 6'h12, 6'h13, 6'h15};
  int pul_bit [4] = '{14, 13, 12, 11};
  logic [5:0] ina_code [7] = '{6'h00, 6'h1a, 6'h1c, 6'h22, 6'h23, 6'h24, 6'h25};

  assign outs = {o3, o2, o1};
  always #12.5 clk = ~clk;

  otfs_top #(.PULSE_CYC(PCYC)) dut (
    .MCLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .STATUS_I(st),
    .FIRST_COLLECTOR_OUTPUT_O(o1), .SECOND_COLLECTOR_OUTPUT_O(o2), .RELAY_OUTPUT_O(o3)
  );

  otfs_load load (
    .clk_i(clk), .clear_i(clear), .line_i(outs),
    .first_cnt_o(c1), .second_cnt_o(c2), .relay_cnt_o(c3)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // No fixed latency assumed: both phases wait for hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic set_all(input logic [5:0] c);
    logic [31:0] x;
    bus(1'b1, OTFS_FIRST_FUNC_ADDR, {26'h0, c}, x);
    bus(1'b1, OTFS_SECOND_FUNC_ADDR, {26'h0, c}, x);
    bus(1'b1, OTFS_RELAY_FUNC_ADDR, {26'h0, c}, x);
  endtask : set_all

  task automatic drive(input logic [18:0] v);
    @(posedge clk);
    st <= otfs_status_t'(v);
  endtask : drive

  task automatic expect_out(input logic [2:0] e);
    repeat (3) @(posedge clk);
    #1;
    check("terminal outputs", {29'h0, outs}, {29'h0, e});
  endtask : expect_out

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Timeout
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done;
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, OTFS_FIRST_FUNC_ADDR, 32'h0, r);
    check("first code", r, {26'h0, OTFS_FIRST_FUNC_RST});
    bus(1'b0, OTFS_SECOND_FUNC_ADDR, 32'h0, r);
    check("second code", r, {26'h0, OTFS_SECOND_FUNC_RST});
    bus(1'b0, OTFS_RELAY_FUNC_ADDR, 32'h0, r);
    check("relay code", r, {26'h0, OTFS_RELAY_FUNC_RST});
    bus(1'b0, OTFS_POLARITY_ADDR, 32'h0, r);
    check("polarity", r, {29'h0, OTFS_POLARITY_RST});
    bus(1'b0, 8'h40, 32'h0, r);
    check("unmapped", r, 32'h0);
    $display("test reset values done");
    bus(1'b1, OTFS_WOBBLE_EN_ADDR, 32'h1, r);
    // Every other status high must not leak onto the chosen code
    foreach (lvl_code[i]) begin
      set_all(lvl_code[i]);
      // The two wobble limits share one code, so neither may be high here
      drive(~(19'h1 << lvl_bit[i]) & ((lvl_code[i] == 6'h0e) ? 19'h1ffff : 19'h7ffff));
      expect_out(3'h0);
      drive(19'h1 << lvl_bit[i]);
      expect_out(3'h7);
    end
    $display("test level codes done");
    bus(1'b1, OTFS_WOBBLE_EN_ADDR, 32'h0, r);
    set_all(6'h0e);
    drive('1);
    expect_out(3'h0);
    foreach (ina_code[i]) begin
      set_all(ina_code[i]);
      expect_out(3'h0);
    end
    set_all(6'h26);
    expect_out(3'h2);
    drive(~19'h1);
    expect_out(3'h0);
    $display("test inactive codes done");
    drive('0);
    set_all(6'h14);
    bus(1'b1, OTFS_LINK_DATA_ADDR, 32'h5, r);
    expect_out(3'h5);
    bus(1'b0, OTFS_STATUS_ADDR, 32'h0, r);
    check("output state", r, 32'h5);
    bus(1'b1, OTFS_LINK_DATA_ADDR, 32'h2, r);
    expect_out(3'h2);
    set_all(6'h00);
    bus(1'b1, OTFS_POLARITY_ADDR, 32'h7, r);
    bus(1'b0, OTFS_POLARITY_ADDR, 32'h0, r);
    check("polarity", r, 32'h7);
    expect_out(3'h7);
    set_all(6'h1f);
    bus(1'b1, OTFS_POLARITY_ADDR, 32'h2, r);
    drive(19'h8);
    expect_out(3'h5);
    bus(1'b1, OTFS_POLARITY_ADDR, 32'h0, r);
    $display("test link and polarity done");
    // Event held high well past the pulse: a level here would overcount
    foreach (pul_code[i]) begin
      drive('0);
      set_all(pul_code[i]);
      repeat (PCYC + 2) @(posedge clk);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      drive(19'h1 << pul_bit[i]);
      repeat (3 * PCYC) @(posedge clk);
      drive('0);
      repeat (PCYC) @(posedge clk);
      check("first pulse", {16'h0, c1}, PCYC);
      check("second pulse", {16'h0, c2}, PCYC);
      check("relay pulse", {16'h0, c3}, PCYC);
    end
    $display("test pulse codes done");
    test_done;
  end
endmodule : otfs_bench
